// ---- verilog/lcm_params.svh ----
// register offsets, reset values and field split of the lan csr bank
`ifndef LCM_PARAMS_SVH
`define LCM_PARAMS_SVH

// ----------------------------------------------------------------------------
// address space
// ----------------------------------------------------------------------------
`define LCM_SPACE_BASE     8'h00
`define LCM_SPACE_END      8'hFC

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LCM_OFS_BUS_CFG    8'h00
`define LCM_OFS_TX_POLL    8'h08
`define LCM_OFS_RX_POLL    8'h10
`define LCM_OFS_RX_BASE    8'h18
`define LCM_OFS_TX_BASE    8'h20
`define LCM_OFS_INT_STAT   8'h28
`define LCM_OFS_NET_CTRL   8'h30
`define LCM_OFS_INT_EN     8'h38
`define LCM_OFS_LOST_CNT   8'h40
`define LCM_OFS_SERIAL     8'h48
`define LCM_OFS_GP_TIMER   8'h58
`define LCM_OFS_WAKEUP     8'h68
`define LCM_OFS_WATCHDOG   8'h78
`define LCM_OFS_STAT2      8'h80
`define LCM_OFS_INT_EN2    8'h84
`define LCM_OFS_COMMAND    8'h88
`define LCM_OFS_PERF_CNT   8'h8C
`define LCM_OFS_PM_CTRL    8'h90
`define LCM_OFS_CUR_TXD    8'h94
`define LCM_OFS_CUR_RXD    8'h98
`define LCM_OFS_TX_BURST   8'h9C
`define LCM_OFS_FLASH      8'hA0
`define LCM_OFS_STA_LO     8'hA4
`define LCM_OFS_STA_HI     8'hA8
`define LCM_OFS_MC_LO      8'hAC
`define LCM_OFS_MC_HI      8'hB0
`define LCM_OFS_UC_LO      8'hB4
`define LCM_OFS_UC_HI      8'hB8
`define LCM_OFS_OP_MODE    8'hFC

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LCM_RST_BUS_CFG    32'h0000_1000
`define LCM_RST_DEFAULT    32'h0000_0000

// ----------------------------------------------------------------------------
// status word split: low half level latches, high half edge latches
// ----------------------------------------------------------------------------
`define LCM_LEVEL_MASK     32'h0000_FFFF

`endif

// ---- verilog/lcm_pkg.sv ----
// types of the lan csr bank
package lcm_pkg;

    // ------------------------------------------------------------------------
    // access kinds of a register word
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        LCM_KIND_NONE    = 4'h0,
        LCM_KIND_RW      = 4'h1,
        LCM_KIND_RWSC    = 4'h2,
        LCM_KIND_RWH     = 4'h3,
        LCM_KIND_RO      = 4'h4,
        LCM_KIND_VIRT    = 4'h5,
        LCM_KIND_LOR     = 4'h6,
        LCM_KIND_STAT_MK = 4'h7,
        LCM_KIND_STAT_SC = 4'h8,
        LCM_KIND_STAT_LO = 4'h9,
        LCM_KIND_IEN     = 4'hA
    } lcm_kind_type;

    // ------------------------------------------------------------------------
    // register port request, word addressed
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } lcm_req_type;

    // ------------------------------------------------------------------------
    // hardware sources
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] int_src;
        logic [31:0] stat2_src;
        logic [31:0] pm_src;
        logic [31:0] lost_cnt;
        logic [31:0] perf_cnt;
        logic [31:0] cur_txd;
        logic [31:0] cur_rxd;
        logic [31:0] serial_in;
        logic [31:0] net_set;
        logic [31:0] net_clr;
        logic [31:0] wake_strap;
    } lcm_hw_in_type;

    // ------------------------------------------------------------------------
    // controls to hardware
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] bus_cfg;
        logic [31:0] tx_poll;
        logic [31:0] rx_poll;
        logic [31:0] rx_base;
        logic [31:0] tx_base;
        logic [31:0] net_ctrl;
        logic [31:0] int_en;
        logic [31:0] gp_timer;
        logic [31:0] wakeup;
        logic [31:0] watchdog;
        logic [31:0] int_en2;
        logic [31:0] command;
        logic [31:0] tx_burst;
        logic [31:0] flash;
        logic [31:0] sta_lo;
        logic [31:0] sta_hi;
        logic [31:0] mc_lo;
        logic [31:0] mc_hi;
        logic [31:0] uc_lo;
        logic [31:0] uc_hi;
        logic [31:0] op_mode;
        logic        tx_poll_stb;
        logic        rx_poll_stb;
    } lcm_ctrl_type;

    // ------------------------------------------------------------------------
    // whole state of the bank
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [63:0][31:0] regs;
        logic [63:0][31:0] prev;
        logic              lor_done;
        logic [1:0]        poll_stb;
        logic [31:0]       rdata;
        logic              rvalid;
        logic              int_req;
    } lcm_state_type;

endpackage

// ---- verilog/lcm_csr_bank.sv ----
// control/status register bank of the lan controller
`timescale 1ns/1ps
`include "lcm_params.svh"

// Overview of operation
// RULE1 - decode every word from byte zero up to and including the top word
// RULE2 - registers are taken only as whole words, never by byte lane
// RULE3 - plain read/write words hold the last write and drive hardware
// RULE4 - writes to hardware-written read fields are ignored
// RULE5 - read-only fields load through one register stage, one clock late
// RULE6 - read-virtual fields have no storage and go straight to read mux
// RULE7 - latch-high fields set while source high, clear on read
// RULE8 - latch-low fields set while source low, clear on read
// RULE9 - mask-clearing fields: written one bits clear, zero bits keep
// RULE10 - edge fields set on rising or falling source edge, clear on read, or by written one bits in the mask-clearing word
// RULE11 - enable words are read/write and gate their status onto interrupt
// RULE12 - latch-on-reset word captures in first cycle after reset, then rw
// RULE13 - self-clearing word turns a write into a one-clock strobe
// RULE14 - hardware-affected word: both sides update, hardware wins same cycle
// RULE15 - operation mode word sits at the last word of the space
// RULE16 - unlisted words read zero and ignore writes
module lcm_csr_bank (
    // clock, reset, enable
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    // register port
    input  wire lcm_pkg::lcm_req_type  i_csr,
    output logic [31:0]                o_csr_rdata,
    output logic                       o_csr_rvalid,
    // hardware side
    input  wire lcm_pkg::lcm_hw_in_type i_hw,
    output lcm_pkg::lcm_ctrl_type      o_ctrl,
    output logic                       o_int_req
);

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic [5:0] lcm_idx(input logic [7:0] ofs);
        return ofs[7:2];
    endfunction

    // one table drives both write behaviour and read mux
    function automatic lcm_pkg::lcm_kind_type lcm_kind(input logic [5:0] idx);
        logic [7:0] ofs;
        ofs = {idx, 2'b00};
        unique case (ofs)
            `LCM_OFS_BUS_CFG, `LCM_OFS_RX_BASE, `LCM_OFS_TX_BASE,
            `LCM_OFS_GP_TIMER, `LCM_OFS_WATCHDOG, `LCM_OFS_COMMAND,
            `LCM_OFS_TX_BURST, `LCM_OFS_FLASH, `LCM_OFS_STA_LO,
            `LCM_OFS_STA_HI, `LCM_OFS_MC_LO, `LCM_OFS_MC_HI,
            `LCM_OFS_UC_LO, `LCM_OFS_UC_HI,
            `LCM_OFS_OP_MODE:                   return lcm_pkg::LCM_KIND_RW;   // [RULE15]
            `LCM_OFS_TX_POLL, `LCM_OFS_RX_POLL: return lcm_pkg::LCM_KIND_RWSC;
            `LCM_OFS_NET_CTRL:                  return lcm_pkg::LCM_KIND_RWH;
            `LCM_OFS_LOST_CNT, `LCM_OFS_PERF_CNT,
            `LCM_OFS_CUR_TXD, `LCM_OFS_CUR_RXD: return lcm_pkg::LCM_KIND_RO;
            `LCM_OFS_SERIAL:                    return lcm_pkg::LCM_KIND_VIRT;
            `LCM_OFS_WAKEUP:                    return lcm_pkg::LCM_KIND_LOR;
            `LCM_OFS_INT_STAT:                  return lcm_pkg::LCM_KIND_STAT_MK;
            `LCM_OFS_STAT2:                     return lcm_pkg::LCM_KIND_STAT_SC;
            `LCM_OFS_PM_CTRL:                   return lcm_pkg::LCM_KIND_STAT_LO;
            `LCM_OFS_INT_EN, `LCM_OFS_INT_EN2:  return lcm_pkg::LCM_KIND_IEN;
            default:                            return lcm_pkg::LCM_KIND_NONE; // [RULE16]
        endcase
    endfunction

    function automatic lcm_pkg::lcm_state_type lcm_reset_state();
        lcm_pkg::lcm_state_type s;
        s = '0;
        for (int i = 0; i < 64; i++) begin
            s.regs[i] = `LCM_RST_DEFAULT;
        end
        s.regs[lcm_idx(`LCM_OFS_BUS_CFG)] = `LCM_RST_BUS_CFG;
        return s;
    endfunction

    localparam lcm_pkg::lcm_state_type RESET_STATE = lcm_reset_state();

    // ------------------------------------------------------------------------
    // hardware sources by word index
    // ------------------------------------------------------------------------
    logic [63:0][31:0] src;

    always_comb begin
        src = '0;
        src[lcm_idx(`LCM_OFS_INT_STAT)] = i_hw.int_src;
        src[lcm_idx(`LCM_OFS_STAT2)]    = i_hw.stat2_src;
        src[lcm_idx(`LCM_OFS_PM_CTRL)]  = i_hw.pm_src;
        src[lcm_idx(`LCM_OFS_LOST_CNT)] = i_hw.lost_cnt;
        src[lcm_idx(`LCM_OFS_PERF_CNT)] = i_hw.perf_cnt;
        src[lcm_idx(`LCM_OFS_CUR_TXD)]  = i_hw.cur_txd;
        src[lcm_idx(`LCM_OFS_CUR_RXD)]  = i_hw.cur_rxd;
        src[lcm_idx(`LCM_OFS_SERIAL)]   = i_hw.serial_in;
        src[lcm_idx(`LCM_OFS_WAKEUP)]   = i_hw.wake_strap;
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    lcm_pkg::lcm_state_type s_q;
    lcm_pkg::lcm_state_type s_d;

    always_comb begin
        logic                  wr;
        logic                  rd;
        logic [31:0]           set_hi;
        logic [31:0]           set_lo;
        logic [31:0]           nxt;
        lcm_pkg::lcm_kind_type kind;
        wr     = 1'b0;
        rd     = 1'b0;
        set_hi = '0;
        set_lo = '0;
        nxt    = '0;
        kind   = lcm_pkg::LCM_KIND_NONE;
        s_d    = s_q;
        s_d.poll_stb = 2'b00;
        s_d.rvalid   = 1'b0;
        // whole 64-word space decoded, address carries no byte lanes
        for (int i = 0; i < 64; i++) begin
            kind = lcm_kind(6'(i));                                         // [RULE1] [RULE2]
            wr   = i_csr.wr && (i_csr.addr == 6'(i));
            rd   = i_csr.rd && (i_csr.addr == 6'(i));
            // low half latches level, high half latches edges
            set_hi = (src[i] & `LCM_LEVEL_MASK)
                   | (src[i] & ~s_q.prev[i] & ~`LCM_LEVEL_MASK);
            set_lo = (~src[i] & `LCM_LEVEL_MASK)
                   | (~src[i] & s_q.prev[i] & ~`LCM_LEVEL_MASK);
            unique case (kind)
                lcm_pkg::LCM_KIND_RW,
                lcm_pkg::LCM_KIND_IEN: begin
                    if (wr) begin
                        s_d.regs[i] = i_csr.wdata;                          // [RULE3] [RULE11]
                    end
                end
                lcm_pkg::LCM_KIND_RWSC: begin
                    // value lives one clock, then hardware wipes it
                    s_d.regs[i] = wr ? i_csr.wdata : `LCM_RST_DEFAULT;     // [RULE13]
                end
                lcm_pkg::LCM_KIND_RWH: begin
                    nxt = wr ? i_csr.wdata : s_q.regs[i];
                    // hardware set/clear applied after the write so it wins
                    s_d.regs[i] = (nxt | i_hw.net_set) & ~i_hw.net_clr;     // [RULE14]
                end
                lcm_pkg::LCM_KIND_RO: begin
                    s_d.regs[i] = src[i];                                   // [RULE4] [RULE5]
                end
                lcm_pkg::LCM_KIND_LOR: begin
                    if (!s_q.lor_done) begin
                        s_d.regs[i] = src[i];                               // [RULE12]
                    end else if (wr) begin
                        s_d.regs[i] = i_csr.wdata;
                    end
                end
                lcm_pkg::LCM_KIND_STAT_MK: begin
                    // set wins over a clear in the same cycle
                    s_d.regs[i] = (s_q.regs[i] & ~(wr ? i_csr.wdata : 32'h0000_0000))
                                | set_hi;                                   // [RULE9] [RULE10]
                end
                lcm_pkg::LCM_KIND_STAT_SC: begin
                    s_d.regs[i] = (rd ? 32'h0000_0000 : s_q.regs[i]) | set_hi; // [RULE7] [RULE10]
                end
                lcm_pkg::LCM_KIND_STAT_LO: begin
                    s_d.regs[i] = (rd ? 32'h0000_0000 : s_q.regs[i]) | set_lo; // [RULE8] [RULE10]
                end
                lcm_pkg::LCM_KIND_VIRT,
                lcm_pkg::LCM_KIND_NONE: begin
                    // no storage: writes dropped
                end
            endcase
            s_d.prev[i] = src[i];
        end
        s_d.lor_done = 1'b1;
        s_d.poll_stb[0] = i_csr.wr && (i_csr.addr == lcm_idx(`LCM_OFS_TX_POLL)); // [RULE13]
        s_d.poll_stb[1] = i_csr.wr && (i_csr.addr == lcm_idx(`LCM_OFS_RX_POLL)); // [RULE13]
        // read data is the value before this cycle's update
        if (i_csr.rd) begin
            s_d.rvalid = 1'b1;
            unique case (lcm_kind(i_csr.addr))
                lcm_pkg::LCM_KIND_NONE: s_d.rdata = 32'h0000_0000;          // [RULE16]
                lcm_pkg::LCM_KIND_VIRT: s_d.rdata = src[i_csr.addr];        // [RULE6]
                default:                s_d.rdata = s_q.regs[i_csr.addr];
            endcase
        end
        s_d.int_req = |(s_d.regs[lcm_idx(`LCM_OFS_INT_STAT)] & s_d.regs[lcm_idx(`LCM_OFS_INT_EN)])
                    | |(s_d.regs[lcm_idx(`LCM_OFS_STAT2)] & s_d.regs[lcm_idx(`LCM_OFS_INT_EN2)]); // [RULE11]
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= RESET_STATE;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign o_csr_rdata         = s_q.rdata;
    assign o_csr_rvalid        = s_q.rvalid;
    assign o_int_req           = s_q.int_req;
    assign o_ctrl.bus_cfg      = s_q.regs[lcm_idx(`LCM_OFS_BUS_CFG)];
    assign o_ctrl.tx_poll      = s_q.regs[lcm_idx(`LCM_OFS_TX_POLL)];
    assign o_ctrl.rx_poll      = s_q.regs[lcm_idx(`LCM_OFS_RX_POLL)];
    assign o_ctrl.rx_base      = s_q.regs[lcm_idx(`LCM_OFS_RX_BASE)];
    assign o_ctrl.tx_base      = s_q.regs[lcm_idx(`LCM_OFS_TX_BASE)];
    assign o_ctrl.net_ctrl     = s_q.regs[lcm_idx(`LCM_OFS_NET_CTRL)];
    assign o_ctrl.int_en       = s_q.regs[lcm_idx(`LCM_OFS_INT_EN)];
    assign o_ctrl.gp_timer     = s_q.regs[lcm_idx(`LCM_OFS_GP_TIMER)];
    assign o_ctrl.wakeup       = s_q.regs[lcm_idx(`LCM_OFS_WAKEUP)];
    assign o_ctrl.watchdog     = s_q.regs[lcm_idx(`LCM_OFS_WATCHDOG)];
    assign o_ctrl.int_en2      = s_q.regs[lcm_idx(`LCM_OFS_INT_EN2)];
    assign o_ctrl.command      = s_q.regs[lcm_idx(`LCM_OFS_COMMAND)];
    assign o_ctrl.tx_burst     = s_q.regs[lcm_idx(`LCM_OFS_TX_BURST)];
    assign o_ctrl.flash        = s_q.regs[lcm_idx(`LCM_OFS_FLASH)];
    assign o_ctrl.sta_lo       = s_q.regs[lcm_idx(`LCM_OFS_STA_LO)];
    assign o_ctrl.sta_hi       = s_q.regs[lcm_idx(`LCM_OFS_STA_HI)];
    assign o_ctrl.mc_lo        = s_q.regs[lcm_idx(`LCM_OFS_MC_LO)];
    assign o_ctrl.mc_hi        = s_q.regs[lcm_idx(`LCM_OFS_MC_HI)];
    assign o_ctrl.uc_lo        = s_q.regs[lcm_idx(`LCM_OFS_UC_LO)];
    assign o_ctrl.uc_hi        = s_q.regs[lcm_idx(`LCM_OFS_UC_HI)];
    assign o_ctrl.op_mode      = s_q.regs[lcm_idx(`LCM_OFS_OP_MODE)];
    assign o_ctrl.tx_poll_stb  = s_q.poll_stb[0];
    assign o_ctrl.rx_poll_stb  = s_q.poll_stb[1];

endmodule

// ---- sim/lcm_csr_monitor.sv ----
// assertion checker watching the ports of the lan csr bank
`timescale 1ns/1ps
module lcm_csr_monitor (
    // clock, reset, enable
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    // register port
    input  wire lcm_pkg::lcm_req_type   i_csr,
    input  wire logic [31:0]            o_csr_rdata,
    input  wire logic                   o_csr_rvalid,
    // hardware side
    input  wire lcm_pkg::lcm_hw_in_type i_hw,
    input  wire lcm_pkg::lcm_ctrl_type  o_ctrl,
    input  wire logic                   o_int_req
);
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    logic        rd_go;
    logic        wr_go;
    logic [31:0] set_only;
    assign rd_go    = i_ce && i_csr.rd;
    assign wr_go    = i_ce && i_csr.wr;
    // clear beats set, so only set bits without a clear must show
    assign set_only = i_hw.net_set & ~i_hw.net_clr;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    a_read_answered: assert property (rd_go |=> o_csr_rvalid)
        else $error("read not answered next cycle");
    a_no_stray_valid: assert property (i_ce && !i_csr.rd |=> !o_csr_rvalid)
        else $error("read valid without a read");
    a_rw_holds_write: assert property (wr_go && i_csr.addr == 6'h2E |=> o_ctrl.uc_hi == $past(i_csr.wdata))
        else $error("rw word did not take the write");
    a_top_word_mode: assert property (wr_go && i_csr.addr == 6'h3F |=> o_ctrl.op_mode == $past(i_csr.wdata))
        else $error("top word is not the mode word");
    a_ro_one_late: assert property (rd_go && i_csr.addr == 6'h10 && $past(i_ce) && !$past(i_rst)
        |=> o_csr_rdata == $past(i_hw.lost_cnt, 2))
        else $error("read-only word not one clock late");
    a_rv_direct: assert property (rd_go && i_csr.addr == 6'h12 |=> o_csr_rdata == $past(i_hw.serial_in))
        else $error("virtual word not read straight");
    a_unlisted_zero: assert property (rd_go && i_csr.addr == 6'h3E |=> o_csr_rdata == 32'h0000_0000)
        else $error("unlisted word read nonzero");
    a_poll_strobe: assert property (wr_go && i_csr.addr == 6'h02
        |=> o_ctrl.tx_poll_stb && o_ctrl.tx_poll == $past(i_csr.wdata))
        else $error("poll write gave no strobe");
    a_poll_self_clear: assert property (i_ce && !(i_csr.wr && i_csr.addr == 6'h02)
        |=> !o_ctrl.tx_poll_stb && o_ctrl.tx_poll == 32'h0000_0000)
        else $error("poll word not cleared");
    a_enable_gates: assert property (o_ctrl.int_en == 32'h0 && o_ctrl.int_en2 == 32'h0 |-> !o_int_req)
        else $error("interrupt without enable");
    a_hw_wins_net: assert property (i_ce |=> (o_ctrl.net_ctrl & $past(i_hw.net_clr)) == 32'h0
        && (o_ctrl.net_ctrl & $past(set_only)) == $past(set_only))
        else $error("hardware lost to software");
endmodule

// ---- sim/lcm_host_model.sv ----
// host model making word-wide register cycles
`timescale 1ns/1ps
module lcm_host_model (
    // clock
    input  wire logic            i_clk_sys,
    // register port
    output lcm_pkg::lcm_req_type o_csr,
    input  wire logic [31:0]     i_csr_rdata,
    input  wire logic            i_csr_rvalid
);
    initial o_csr = '0;

    // released lines show inverted values, never the old ones
    task automatic idle();
        o_csr.wr    = 1'b0;
        o_csr.rd    = 1'b0;
        o_csr.addr  = ~o_csr.addr;
        o_csr.wdata = ~o_csr.wdata;
    endtask

    task automatic write(input logic [7:0] ofs, input logic [31:0] data);
        @(posedge i_clk_sys);
        #1;
        o_csr.addr  = ofs[7:2];
        o_csr.wdata = data;
        o_csr.wr    = 1'b1;
        @(posedge i_clk_sys);
        #1;
        idle();
    endtask

    task automatic read(input logic [7:0] ofs, output logic [31:0] data, output logic valid);
        @(posedge i_clk_sys);
        #1;
        o_csr.addr = ofs[7:2];
        o_csr.rd   = 1'b1;
        @(posedge i_clk_sys);
        #1;
        idle();
        data  = i_csr_rdata;
        valid = i_csr_rvalid;
    endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking testbench of the lan csr bank
`timescale 1ns/1ps
`include "lcm_params.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    logic                   clk;
    logic                   rst;
    logic                   ce;
    logic                   rvalid;
    logic                   int_req;
    logic [31:0]            rdata;
    lcm_pkg::lcm_req_type   csr;
    lcm_pkg::lcm_hw_in_type hw;
    lcm_pkg::lcm_ctrl_type  ctrl;
    int                     err_total;
    int                     comparisons;
    logic [7:0] ofs_tab [18] = '{8'h00, 8'h18, 8'h20, 8'h58, 8'h78, 8'h88, 8'h9C, 8'hA0, 8'hA4,
                                 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hFC, 8'h04, 8'h50, 8'hF8};

    lcm_csr_bank DUT (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_csr(csr), .o_csr_rdata(rdata),
                      .o_csr_rvalid(rvalid), .i_hw(hw), .o_ctrl(ctrl), .o_int_req(int_req));
    lcm_host_model host (.i_clk_sys(clk), .o_csr(csr), .i_csr_rdata(rdata), .i_csr_rvalid(rvalid));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] pat(input logic [7:0] ofs);
        return {8'hC3, ofs, 8'h5A, ~ofs};
    endfunction

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        host.read(ofs, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(`LCM_OFS_BUS_CFG, `LCM_RST_BUS_CFG);
        rd_chk(`LCM_OFS_WAKEUP, 32'h0000_00A5);
        host.write(`LCM_OFS_WAKEUP, 32'h0000_005A);
        rd_chk(`LCM_OFS_WAKEUP, 32'h0000_005A);
        `CHK(ctrl.wakeup, 32'h0000_005A)
    endtask

    // all writes first, so any aliasing between words shows on read back
    task automatic t_map();
        for (int i = 0; i < 18; i++) host.write(ofs_tab[i], pat(ofs_tab[i]));
        for (int i = 0; i < 18; i++) rd_chk(ofs_tab[i], (i < 15) ? pat(ofs_tab[i]) : 32'h0);
        `CHK(ctrl.op_mode, pat(8'hFC))
        `CHK({ctrl.bus_cfg, ctrl.rx_base, ctrl.tx_base}, {pat(8'h00), pat(8'h18), pat(8'h20)})
        `CHK({ctrl.gp_timer, ctrl.watchdog, ctrl.command}, {pat(8'h58), pat(8'h78), pat(8'h88)})
        `CHK({ctrl.tx_burst, ctrl.flash, ctrl.sta_lo}, {pat(8'h9C), pat(8'hA0), pat(8'hA4)})
        `CHK({ctrl.sta_hi, ctrl.mc_lo, ctrl.mc_hi}, {pat(8'hA8), pat(8'hAC), pat(8'hB0)})
        `CHK({ctrl.uc_lo, ctrl.uc_hi}, {pat(8'hB4), pat(8'hB8)})
        ce = 1'b0;
        host.write(8'hB8, 32'h0000_0000);
        ce = 1'b1;
        rd_chk(8'hB8, pat(8'hB8));
    endtask

    task automatic t_ro();
        hw.lost_cnt  = 32'h1234_5678;
        hw.serial_in = 32'h8765_4321;
        host.write(`LCM_OFS_LOST_CNT, 32'h0000_0000);
        host.write(`LCM_OFS_SERIAL, 32'h0000_0000);
        rd_chk(`LCM_OFS_LOST_CNT, 32'h1234_5678);
        rd_chk(`LCM_OFS_SERIAL, 32'h8765_4321);
    endtask

    task automatic t_latch();
        hw.int_src   = 32'h0001_0001;
        hw.stat2_src = 32'h0001_0002;
        hw.pm_src    = 32'hFFFD_FFFB;
        @(posedge clk);
        #1;
        hw.int_src   = 32'h0001_0000;
        hw.stat2_src = 32'h0001_0000;
        hw.pm_src    = 32'hFFFF_FFFF;
        rd_chk(`LCM_OFS_INT_STAT, 32'h0001_0001);
        rd_chk(`LCM_OFS_INT_STAT, 32'h0001_0001);
        host.write(`LCM_OFS_INT_EN, 32'h0000_0001);
        `CHK(int_req, 1'b1)
        `CHK({ctrl.int_en, ctrl.int_en2}, {32'h0000_0001, 32'h0000_0000})
        host.write(`LCM_OFS_INT_EN, 32'h0000_0000);
        `CHK(int_req, 1'b0)
        host.write(`LCM_OFS_INT_STAT, 32'h0000_0001);
        rd_chk(`LCM_OFS_INT_STAT, 32'h0001_0000);
        host.write(`LCM_OFS_INT_STAT, 32'h0001_0000);
        rd_chk(`LCM_OFS_INT_STAT, 32'h0000_0000);
        rd_chk(`LCM_OFS_STAT2, 32'h0001_0002);
        rd_chk(`LCM_OFS_STAT2, 32'h0000_0000);
        rd_chk(`LCM_OFS_PM_CTRL, 32'h0002_0004);
        rd_chk(`LCM_OFS_PM_CTRL, 32'h0000_0000);
        hw.int_src = 32'h0000_0000;
    endtask

    task automatic t_poll_net();
        host.write(`LCM_OFS_TX_POLL, 32'h0000_0001);
        `CHK({ctrl.tx_poll_stb, ctrl.tx_poll}, {1'b1, 32'h0000_0001})
        @(posedge clk);
        #1;
        `CHK({ctrl.tx_poll_stb, ctrl.tx_poll}, {1'b0, 32'h0000_0000})
        host.write(`LCM_OFS_RX_POLL, 32'h0000_0001);
        `CHK({ctrl.rx_poll_stb, ctrl.rx_poll}, {1'b1, 32'h0000_0001})
        hw.net_set = 32'h0000_0008;
        hw.net_clr = 32'h0000_0100;
        host.write(`LCM_OFS_NET_CTRL, 32'h0000_0F00);
        `CHK(ctrl.net_ctrl, 32'h0000_0E08)
        hw.net_set = 32'h0000_0000;
        hw.net_clr = 32'h0000_0000;
        host.write(`LCM_OFS_NET_CTRL, 32'h0000_0000);
        `CHK(ctrl.net_ctrl, 32'h0000_0000)
    endtask

    // ------------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        err_total      = 0;
        comparisons    = 0;
        rst            = 1'b1;
        ce             = 1'b1;
        hw             = '0;
        hw.pm_src      = 32'hFFFF_FFFF;
        hw.wake_strap  = 32'h0000_00A5;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_map();
        t_ro();
        t_latch();
        t_poll_net();
        results();
    end

    // whole run is under 150 cycles; this is far beyond it
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule

bind lcm_csr_bank lcm_csr_monitor mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_csr(i_csr),
    .o_csr_rdata(o_csr_rdata), .o_csr_rvalid(o_csr_rvalid), .i_hw(i_hw), .o_ctrl(o_ctrl), .o_int_req(o_int_req));
